// *** common/icd_map.svh ***
// Address map, command field codes and reset values of the command decoder.
// Assumes the includer uses 16-bit bus data and 5-bit byte addresses.
`ifndef ICD_MAP_SVH
`define ICD_MAP_SVH

// Byte offsets of the ports on the register port
`define ICD_OFS_CMD1      5'h00
`define ICD_OFS_DATA1     5'h04
`define ICD_OFS_CMD2      5'h08
`define ICD_OFS_DATA2     5'h0c
`define ICD_OFS_STAT1     5'h10
`define ICD_OFS_STAT2     5'h14

// Whole-command and field codes
`define ICD_CMD_RESET     8'h00
`define ICD_OP5_CLR_PM    5'h02
`define ICD_OP5_CLR_PM_B  5'h03
`define ICD_OP5_CLR_M     5'h04
`define ICD_OP5_CLR_M_B   5'h05
`define ICD_OP5_SET_M     5'h06
`define ICD_OP5_SET_M_B   5'h07
`define ICD_OP5_CLR_P     5'h08
`define ICD_OP5_CLR_P_B   5'h09
`define ICD_OP5_SET_P     5'h0a
`define ICD_OP5_SET_P_B   5'h0b
`define ICD_OP5_CLR_S     5'h0e
`define ICD_OP5_CLR_S_B   5'h0f
`define ICD_OP4_CLR_S_HI  4'h6
`define ICD_OP4_MODE_HI   4'ha
`define ICD_OP4_PRE_MASK  4'hb
`define ICD_OP4_PRE_AC    4'hc
`define ICD_OP3_MODE_LO   3'h4
`define ICD_OP3_PRE_VEC   3'h7

// Master mask control field codes
`define ICD_MM_KEEP       2'h0
`define ICD_MM_SET        2'h1
`define ICD_MM_CLR        2'h2

// Field positions inside the mode register
`define ICD_MODE_LO_MSB   4
`define ICD_MODE_HI_MSB   6
`define ICD_MODE_HI_LSB   5
`define ICD_MM_BIT        7

// Reset values, one-bit base and pointer step
`define ICD_ALL_ONES      8'hff
`define ICD_ALL_ZEROS     8'h00
`define ICD_ONE_BIT       8'h01
`define ICD_COUNT_RST     2'h0
`define ICD_PTR_ZERO      2'h0
`define ICD_PTR_STEP      2'h1

`endif

// *** common/icd_pkg.sv ***
// Types shared by the command decoder and its vector memory.
// Assumes icd_map.svh holds the numeric constants.
package icd_pkg;

    typedef enum logic [1:0] {
        ICD_TGT_NONE,
        ICD_TGT_MASK,
        ICD_TGT_AUTOCLEAR,
        ICD_TGT_VECTOR
    } icd_target_t;

    // Register state of one group, as seen by the rest of the chip
    typedef struct packed {
        logic [7:0] mode_reg;
        logic [7:0] pending_reg;
        logic [7:0] mask_reg;
        logic [7:0] service_reg;
        logic [7:0] autoclear_reg;
    } icd_grp_t;

    // Events from the priority and acknowledge logic of one group
    typedef struct packed {
        logic [7:0] pend_set;
        logic [7:0] svc_set;
        logic       pop;
        logic [2:0] pop_level;
    } icd_evt_t;

    // One vector byte read out of the vector memory
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } icd_vec_t;

endpackage

// *** core/icd_vecmem.sv ***
// Vector memory of one group: eight levels of four bytes, each a FIFO ring.
// Assumes writes and pops arrive as one-cycle pulses from the decoder.
`timescale 1ns/1ps
`include "icd_map.svh"

module icd_vecmem
(
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    // Preselect and data writes
    input  wire logic             presel_i,
    input  wire logic [2:0]       presel_level_i,
    input  wire logic [1:0]       presel_count_i,
    input  wire logic             wr_i,
    input  wire logic [7:0]       wr_data_i,
    // Read-out side
    input  wire logic             pop_i,
    input  wire logic [2:0]       pop_level_i,
    output icd_pkg::icd_vec_t     vec_o,
    output logic      [1:0]       count_o [8]
);
    import icd_pkg::*;

    logic [7:0] mem_r      [32];
    logic [1:0] wr_ptr_r   [8];
    logic [1:0] rd_ptr_r   [8];
    logic [1:0] count_r    [8];
    logic [2:0] wr_level_r;

    assign count_o = count_r;

    // Memory contents survive every reset
    always_ff @(posedge ref_clk_i)
    begin
        if (wr_i)
            mem_r[{wr_level_r, wr_ptr_r[wr_level_r]}] <= wr_data_i; // [RULE13]
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            wr_level_r <= 3'h0;
        else if (presel_i)
            wr_level_r <= presel_level_i;
    end

    // Byte count only bounds reads; writes never stop at it
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                wr_ptr_r[i] <= `ICD_PTR_ZERO;
                rd_ptr_r[i] <= `ICD_PTR_ZERO;
                count_r[i]  <= `ICD_COUNT_RST;
            end
        end
        else
        begin
            if (presel_i)
            begin
                wr_ptr_r[presel_level_i] <= `ICD_PTR_ZERO;
                rd_ptr_r[presel_level_i] <= `ICD_PTR_ZERO;
                count_r[presel_level_i]  <= presel_count_i; // [RULE12]
            end
            else if (wr_i)
                wr_ptr_r[wr_level_r] <= wr_ptr_r[wr_level_r] + `ICD_PTR_STEP; // [RULE13]
            if (pop_i && !(presel_i && presel_level_i == pop_level_i))
            begin
                // Read order follows write order, wrapping after count bytes
                if (rd_ptr_r[pop_level_i] == count_r[pop_level_i])
                    rd_ptr_r[pop_level_i] <= `ICD_PTR_ZERO; // [RULE14]
                else
                    rd_ptr_r[pop_level_i] <= rd_ptr_r[pop_level_i] + `ICD_PTR_STEP; // [RULE14]
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            vec_o <= '0;
        else
        begin
            vec_o.valid <= pop_i;
            if (pop_i)
                vec_o.data <= mem_r[{pop_level_i, rd_ptr_r[pop_level_i]}]; // [RULE14]
        end
    end

endmodule

// *** core/icd_top.sv ***
// What this block does
// [RULE1] Commands go to low byte of command port
// [RULE2] Reset command: mask ones, others cleared
// [RULE3] Clear one service bit; zero stays zero
// [RULE4] Load mode bits 4..0 from command
// [RULE5] Load mode bits 6,5 from bits 3,2
// [RULE6] Low field keeps, sets or clears master mask
// [RULE7] Illegal field code keeps master mask bit
// [RULE8] Mask preselect routes data writes until next command
// [RULE9] Autoclear preselect routes data writes until next command
// [RULE10] Reads never disturb the preselected target
// [RULE11] Mask and autoclear preselects leave mode alone
// [RULE12] Vector preselect stores count, selects level
// [RULE13] Count limits reads, not writes
// [RULE14] Vector bytes read out in write order
// [RULE15] Software writes exactly count vector bytes
// [RULE16] Software should write one vector, count one
// [RULE17] Bit selector is a plain binary index
// [RULE18] Reset, clear pending and mask, clear pending
// [RULE19] Clear same bit in pending and mask
// [RULE20] Clear all mask bits or one
// [RULE21] Set all mask bits or one
//
// Command decoder of a two-group, eight-level interrupt controller.
// Assumes a single-clock register port with one-cycle strobes.
`timescale 1ns/1ps
`include "icd_map.svh"

module icd_top
(
    // Clock and reset
    input  wire logic                 ref_clk_i,
    input  wire logic                 rst_i,
    // Register port
    input  wire logic [4:0]           addr_i,
    input  wire logic [15:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [15:0]          rdata_o,
    // Priority and acknowledge logic
    input  icd_pkg::icd_evt_t [1:0]   evt_i,
    output icd_pkg::icd_grp_t [1:0]   grp_o,
    output icd_pkg::icd_vec_t [1:0]   vec_o
);
    import icd_pkg::*;

    icd_target_t target_r [2];
    logic [1:0]  count_w  [2][8];
    logic [1:0]  cmd_wr;
    logic [1:0]  data_wr;

    // Only the low byte of each command port carries a command
    assign cmd_wr[0]  = wr_i && (addr_i == `ICD_OFS_CMD1); // [RULE1]
    assign cmd_wr[1]  = wr_i && (addr_i == `ICD_OFS_CMD2); // [RULE1]
    assign data_wr[0] = wr_i && (addr_i == `ICD_OFS_DATA1);
    assign data_wr[1] = wr_i && (addr_i == `ICD_OFS_DATA2);

    for (genvar g = 0; g < 2; g++)
    begin : grp
        logic [7:0] cmd;
        logic [4:0] op5;
        logic [3:0] op4;
        logic [2:0] op3;
        logic [7:0] sel_bit;
        logic [7:0] svc_top;
        logic       is_reset;
        logic       presel_vec;
        logic       data_mask;
        logic       data_ac;
        logic       data_vec;

        assign cmd      = wdata_i[7:0]; // [RULE1]
        assign op5      = cmd[7:3];
        assign op4      = cmd[7:4];
        assign op3      = cmd[7:5];
        assign sel_bit  = `ICD_ONE_BIT << cmd[2:0]; // [RULE17]
        assign svc_top  = grp_o[g].service_reg & (~grp_o[g].service_reg + `ICD_ONE_BIT);
        assign is_reset = cmd_wr[g] && (cmd == `ICD_CMD_RESET);
        assign presel_vec = cmd_wr[g] && (op3 == `ICD_OP3_PRE_VEC);
        assign data_mask  = data_wr[g] && (target_r[g] == ICD_TGT_MASK);
        assign data_ac    = data_wr[g] && (target_r[g] == ICD_TGT_AUTOCLEAR);
        assign data_vec   = data_wr[g] && (target_r[g] == ICD_TGT_VECTOR);

        // Write target: only a command write changes it, reads never do
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                target_r[g] <= ICD_TGT_NONE;
            else if (cmd_wr[g])
            begin
                if (op4 == `ICD_OP4_PRE_MASK)
                    target_r[g] <= ICD_TGT_MASK; // [RULE8] [RULE10]
                else if (op4 == `ICD_OP4_PRE_AC)
                    target_r[g] <= ICD_TGT_AUTOCLEAR; // [RULE9] [RULE10]
                else if (op3 == `ICD_OP3_PRE_VEC)
                    target_r[g] <= ICD_TGT_VECTOR; // [RULE12]
                else
                    target_r[g] <= ICD_TGT_NONE; // [RULE8] [RULE9]
            end
        end

        // Pending: a request arriving with a clear still lands
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                grp_o[g].pending_reg <= `ICD_ALL_ZEROS;
            else if (cmd_wr[g])
            begin
                if (is_reset)
                    grp_o[g].pending_reg <= evt_i[g].pend_set; // [RULE2] [RULE18]
                else
                begin
                    case (op5)
                        `ICD_OP5_CLR_PM, `ICD_OP5_CLR_P:
                            grp_o[g].pending_reg <= evt_i[g].pend_set; // [RULE18]
                        `ICD_OP5_CLR_PM_B, `ICD_OP5_CLR_P_B:
                            grp_o[g].pending_reg <= (grp_o[g].pending_reg & ~sel_bit)
                                                    | evt_i[g].pend_set; // [RULE19]
                        `ICD_OP5_SET_P:
                            grp_o[g].pending_reg <= `ICD_ALL_ONES;
                        `ICD_OP5_SET_P_B:
                            grp_o[g].pending_reg <= grp_o[g].pending_reg | sel_bit
                                                    | evt_i[g].pend_set;
                        default:
                            grp_o[g].pending_reg <= grp_o[g].pending_reg
                                                    | evt_i[g].pend_set;
                    endcase
                end
            end
            else
                grp_o[g].pending_reg <= grp_o[g].pending_reg | evt_i[g].pend_set;
        end

        // Mask: command edits and preselected data writes
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                grp_o[g].mask_reg <= `ICD_ALL_ONES;
            else if (data_mask)
                grp_o[g].mask_reg <= wdata_i[7:0]; // [RULE8]
            else if (cmd_wr[g])
            begin
                if (is_reset)
                    grp_o[g].mask_reg <= `ICD_ALL_ONES; // [RULE2]
                else
                begin
                    case (op5)
                        `ICD_OP5_CLR_PM, `ICD_OP5_CLR_M:
                            grp_o[g].mask_reg <= `ICD_ALL_ZEROS; // [RULE18] [RULE20]
                        `ICD_OP5_CLR_PM_B, `ICD_OP5_CLR_M_B:
                            grp_o[g].mask_reg <= grp_o[g].mask_reg & ~sel_bit; // [RULE19] [RULE20]
                        `ICD_OP5_SET_M:
                            grp_o[g].mask_reg <= `ICD_ALL_ONES; // [RULE21]
                        `ICD_OP5_SET_M_B:
                            grp_o[g].mask_reg <= grp_o[g].mask_reg | sel_bit; // [RULE21]
                        default:
                            grp_o[g].mask_reg <= grp_o[g].mask_reg;
                    endcase
                end
            end
        end

        // Service: acknowledge sets a bit unless that level auto-clears
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                grp_o[g].service_reg <= `ICD_ALL_ZEROS;
            else
            begin
                logic [7:0] svc_set;
                logic [7:0] svc_clr;
                svc_set = evt_i[g].svc_set & ~grp_o[g].autoclear_reg;
                svc_clr = `ICD_ALL_ZEROS;
                if (is_reset)
                    svc_clr = `ICD_ALL_ONES; // [RULE2]
                else if (cmd_wr[g] && op4 == `ICD_OP4_CLR_S_HI)
                    svc_clr = svc_top;
                else if (cmd_wr[g] && op5 == `ICD_OP5_CLR_S)
                    svc_clr = `ICD_ALL_ONES;
                else if (cmd_wr[g] && op5 == `ICD_OP5_CLR_S_B)
                    svc_clr = sel_bit; // [RULE3] [RULE17]
                // A clear of a zero bit leaves it zero; set beats clear
                grp_o[g].service_reg <= (grp_o[g].service_reg & ~svc_clr) | svc_set; // [RULE3]
            end
        end

        // Auto-clear: loaded through the data port, cleared by the reset command
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                grp_o[g].autoclear_reg <= `ICD_ALL_ZEROS;
            else if (is_reset)
                grp_o[g].autoclear_reg <= `ICD_ALL_ZEROS; // [RULE2]
            else if (data_ac)
                grp_o[g].autoclear_reg <= wdata_i[7:0]; // [RULE9]
        end

        // Mode: preselect commands fall to the default and keep it
        always_ff @(posedge ref_clk_i or posedge rst_i)
        begin
            if (rst_i)
                grp_o[g].mode_reg <= `ICD_ALL_ZEROS;
            else if (is_reset)
                grp_o[g].mode_reg <= `ICD_ALL_ZEROS; // [RULE2]
            else if (cmd_wr[g] && op3 == `ICD_OP3_MODE_LO)
                grp_o[g].mode_reg[`ICD_MODE_LO_MSB:0] <= cmd[`ICD_MODE_LO_MSB:0]; // [RULE4]
            else if (cmd_wr[g] && op4 == `ICD_OP4_MODE_HI)
            begin
                grp_o[g].mode_reg[`ICD_MODE_HI_MSB:`ICD_MODE_HI_LSB] <= cmd[3:2]; // [RULE5] [RULE7]
                case (cmd[1:0])
                    `ICD_MM_SET:
                        grp_o[g].mode_reg[`ICD_MM_BIT] <= 1'b1; // [RULE6]
                    `ICD_MM_CLR:
                        grp_o[g].mode_reg[`ICD_MM_BIT] <= 1'b0; // [RULE6]
                    default:
                        grp_o[g].mode_reg[`ICD_MM_BIT] <= grp_o[g].mode_reg[`ICD_MM_BIT]; // [RULE6] [RULE7]
                endcase
            end
            else
                grp_o[g].mode_reg <= grp_o[g].mode_reg; // [RULE11]
        end

        // Software is trusted to write exactly count bytes per level
        icd_vecmem u_vecmem
        (
            .ref_clk_i      (ref_clk_i),
            .rst_i          (rst_i),
            .presel_i       (presel_vec), // [RULE12]
            .presel_level_i (cmd[2:0]),
            .presel_count_i (cmd[4:3]),
            .wr_i           (data_vec), // [RULE15]
            .wr_data_i      (wdata_i[7:0]),
            .pop_i          (evt_i[g].pop),
            .pop_level_i    (evt_i[g].pop_level),
            .vec_o          (vec_o[g]),
            .count_o        (count_w[g])
        );
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            rdata_o <= 16'h0000;
        else if (rd_i)
        begin
            case (addr_i)
                `ICD_OFS_CMD1:
                    rdata_o <= {grp_o[0].service_reg, grp_o[0].pending_reg};
                `ICD_OFS_DATA1:
                    rdata_o <= {grp_o[0].autoclear_reg, grp_o[0].mask_reg};
                `ICD_OFS_CMD2:
                    rdata_o <= {grp_o[1].service_reg, grp_o[1].pending_reg};
                `ICD_OFS_DATA2:
                    rdata_o <= {grp_o[1].autoclear_reg, grp_o[1].mask_reg};
                `ICD_OFS_STAT1:
                    rdata_o <= {6'h00, target_r[0], grp_o[0].mode_reg};
                `ICD_OFS_STAT2:
                    rdata_o <= {6'h00, target_r[1], grp_o[1].mode_reg};
                default:
                    rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end

endmodule

// *** test/icd_top_properties.sv ***
// Concurrent checks on the group 1 side of the command decoder.
// Assumes it is bound to icd_top and sees only its ports.
`timescale 1ns/1ps
module icd_top_properties
(
    // Clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             rst_i,
    // Register port
    input  wire logic [4:0]       addr_i,
    input  wire logic [15:0]      wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    input  wire logic [15:0]      rdata_o,
    // Events and state
    input  icd_pkg::icd_evt_t [1:0] evt_i,
    input  icd_pkg::icd_grp_t [1:0] grp_o,
    input  icd_pkg::icd_vec_t [1:0] vec_o
);
    import icd_pkg::*;
    logic       cmd_w;
    logic       dat_w;
    logic       quiet;
    logic [7:0] cb;
    icd_grp_t   g;
    // Hardware sets win over clears, so clears are judged only without events
    assign cmd_w = wr_i && addr_i == 5'h00;
    assign dat_w = wr_i && addr_i == 5'h04;
    assign quiet = evt_i[0].pend_set == 8'h00 && evt_i[0].svc_set == 8'h00;
    assign cb    = wdata_i[7:0];
    assign g     = grp_o[0];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    AST_RESET_CMD: assert property (cmd_w && cb == 8'h00 && quiet |=>
        g.mask_reg == 8'hff && g.pending_reg == 8'h00 && g.service_reg == 8'h00
        && g.autoclear_reg == 8'h00 && g.mode_reg == 8'h00)
        else $error("Reset command left wrong state");
    AST_CLR_SVC_BIT: assert property (cmd_w && cb[7:3] == 5'h0f && quiet |=>
        g.service_reg == ($past(g.service_reg) & ~(8'h01 << $past(cb[2:0]))))
        else $error("Service bit clear wrong");
    AST_MODE_LO: assert property (cmd_w && cb[7:5] == 3'h4 |=>
        g.mode_reg == {$past(g.mode_reg[7:5]), $past(cb[4:0])})
        else $error("Mode low load wrong");
    AST_MODE_HI: assert property (cmd_w && cb[7:4] == 4'ha |=>
        g.mode_reg[6:5] == $past(cb[3:2]) && $stable(g.mode_reg[4:0]))
        else $error("Mode high load wrong");
    AST_MM_BIT: assert property (cmd_w && cb[7:4] == 4'ha |=>
        g.mode_reg[7] == ($past(cb[1:0]) == 2'h1 ? 1'b1 :
        $past(cb[1:0]) == 2'h2 ? 1'b0 : $past(g.mode_reg[7])))
        else $error("Master mask bit wrong");
    AST_MASK_PRESEL: assert property (cmd_w && cb[7:4] == 4'hb ##1 dat_w |=>
        g.mask_reg == $past(cb))
        else $error("Mask data write lost");
    AST_AC_PRESEL: assert property (cmd_w && cb[7:4] == 4'hc ##1 dat_w |=>
        g.autoclear_reg == $past(cb))
        else $error("Autoclear data write lost");
    AST_PRESEL_MODE: assert property (cmd_w && (cb[7:4] == 4'hb || cb[7:4] == 4'hc)
        |=> $stable(g.mode_reg))
        else $error("Preselect changed mode");
    AST_CLR_PM_BIT: assert property (cmd_w && cb[7:3] == 5'h03 && quiet |=>
        g.mask_reg == ($past(g.mask_reg) & ~(8'h01 << $past(cb[2:0])))
        && g.pending_reg == ($past(g.pending_reg) & ~(8'h01 << $past(cb[2:0]))))
        else $error("Pending and mask bit clear wrong");
    AST_MASK_ALL: assert property (cmd_w && (cb[7:3] == 5'h04 || cb[7:3] == 5'h06)
        |=> g.mask_reg == {8{$past(cb[4])}})
        else $error("Whole mask set or clear wrong");
    AST_CLR_PEND: assert property (cmd_w && cb[7:3] == 5'h08 && quiet |=>
        g.pending_reg == 8'h00)
        else $error("Pending clear wrong");
endmodule

// *** test/icd_host.sv ***
// Host processor model on the register port of the command decoder.
// Assumes one-cycle strobes and read data in the cycle after the strobe.
`timescale 1ns/1ps
module icd_host
(
    // Clock
    input  wire logic        ref_clk_i,
    // Register port
    output logic      [4:0]  addr_o,
    output logic      [15:0] wdata_o,
    output logic             wr_o,
    output logic             rd_o,
    input  wire logic [15:0] rdata_i
);
    initial
    begin
        addr_o  = 5'h00;
        wdata_o = 16'h0000;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
    end
    // Strobe stays up so a next transfer may follow with no gap
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        addr_o  <= a;
        wdata_o <= {8'h00, d};
        wr_o    <= 1'b1;
        rd_o    <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] q);
        addr_o <= a;
        rd_o   <= 1'b1;
        wr_o   <= 1'b0;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
        #1;
        q = rdata_i;
    endtask
    task automatic idle();
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // Writes exactly as many bytes as the count code asks for
    task automatic wr_vec(input logic [2:0] lvl, input logic [1:0] cnt, input logic [31:0] v);
        wr_reg(5'h00, {3'h7, cnt, lvl});
        for (int i = 0; i <= cnt; i++)
            wr_reg(5'h04, v[8*i +: 8]);
    endtask
endmodule

// *** test/icd_top_tb.sv ***
// Self-checking bench of the command decoder.
// Assumes icd_host drives the register port; the bench drives the events.
`timescale 1ns/1ps
module icd_top_tb;
    import icd_pkg::*;
    localparam int NROWS = 18;
    // Each row: command, then mode, pending and mask expected after it
    localparam logic [31:0] ROWS [NROWS] = '{
        32'h5000_ffff, 32'h1b00_f7f7, 32'h4800_f6f7, 32'h4000_00f7, 32'h2f00_0077,
        32'h3b00_007f, 32'h2000_0000, 32'h3800_0001, 32'h3000_00ff, 32'h9f1f_00ff,
        32'ha5bf_00ff, 32'haa5f_00ff, 32'hac7f_00ff, 32'ha19f_00ff, 32'ha7bf_00ff,
        32'h5abf_04ff, 32'h10bf_0000, 32'h0000_00ff
    };
    logic                ref_clk = 1'b0;
    logic                rst     = 1'b1;
    logic [4:0]          addr;
    logic [15:0]         wdata;
    logic                wr;
    logic                rd;
    logic [15:0]         rdata;
    logic [15:0]         q;
    icd_evt_t [1:0]      evt     = '0;
    icd_grp_t [1:0]      grp;
    icd_vec_t [1:0]      vec;
    int                  miscompares = 0;
    int                  num_checks  = 0;
    int                  cycles      = 0;
    always #25 ref_clk = ~ref_clk;
    icd_host host_u (.ref_clk_i(ref_clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .rdata_i(rdata));
    icd_top dut_u (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .evt_i(evt), .grp_o(grp), .vec_o(vec));
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic pop(input logic [2:0] lvl, input logic [7:0] e);
        @(posedge ref_clk);
        evt[0].pop       <= 1'b1;
        evt[0].pop_level <= lvl;
        @(posedge ref_clk);
        evt[0].pop <= 1'b0;
        #1;
        chk_byte("vec valid", 8'h01, {7'h00, vec[0].valid});
        chk_byte("vec data", e, vec[0].data);
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Ceiling is some thirty-five times the length of the whole sequence
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < NROWS; i++)
        begin
            host_u.wr_reg(5'h00, ROWS[i][31:24]);
            host_u.idle();
            #1;
            chk_byte("mode", ROWS[i][23:16], grp[0].mode_reg);
            chk_byte("pending", ROWS[i][15:8], grp[0].pending_reg);
            chk_byte("mask", ROWS[i][7:0], grp[0].mask_reg);
        end
        $display("Test command rows done");
        host_u.wr_reg(5'h00, 8'hb0);
        host_u.wr_reg(5'h04, 8'h55);
        host_u.rd_reg(5'h10, q);
        chk_word("status", 16'h0100, q);
        host_u.rd_reg(5'h04, q);
        chk_word("data port", 16'h0055, q);
        host_u.wr_reg(5'h04, 8'h3c);
        host_u.wr_reg(5'h00, 8'h83);
        host_u.wr_reg(5'h04, 8'h99);
        host_u.idle();
        #1;
        chk_byte("mask", 8'h3c, grp[0].mask_reg);
        $display("Test mask preselect done");
        host_u.wr_reg(5'h00, 8'hc0);
        host_u.wr_reg(5'h04, 8'ha5);
        host_u.idle();
        evt[0].svc_set <= 8'h0e;
        @(posedge ref_clk);
        evt[0].svc_set <= 8'h00;
        host_u.wr_reg(5'h00, 8'h79);
        host_u.wr_reg(5'h00, 8'h79);
        host_u.idle();
        #1;
        chk_byte("autoclear", 8'ha5, grp[0].autoclear_reg);
        chk_byte("service", 8'h08, grp[0].service_reg);
        $display("Test autoclear and service done");
        host_u.wr_vec(3'h2, 2'h1, 32'h0000_2211);
        // One byte past the count still lands in the next slot
        host_u.wr_reg(5'h04, 8'h33);
        host_u.idle();
        pop(3'h2, 8'h11);
        pop(3'h2, 8'h22);
        pop(3'h2, 8'h11);
        host_u.wr_vec(3'h5, 2'h0, 32'h0000_0042);
        host_u.idle();
        pop(3'h5, 8'h42);
        pop(3'h5, 8'h42);
        $display("Test vector memory done");
        host_u.wr_reg(5'h08, 8'h20);
        host_u.rd_reg(5'h1c, q);
        chk_word("unmapped", 16'h0000, q);
        chk_byte("mask group 2", 8'h00, grp[1].mask_reg);
        chk_byte("mask group 1", 8'h3c, grp[0].mask_reg);
        $display("Test group 2 done");
        host_u.idle();
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk_byte("mask", 8'hff, grp[0].mask_reg);
        chk_byte("autoclear", 8'h00, grp[0].autoclear_reg);
        chk_byte("service", 8'h00, grp[0].service_reg);
        rst <= 1'b0;
        @(posedge ref_clk);
        $display("Test reset done");
        give_verdict();
    end
endmodule
bind icd_top icd_top_properties chk_u (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .evt_i, .grp_o, .vec_o);
